// File: rics_pkg.sv
// Shared constants for the regulator configuration serial slave.
package rics_pkg;
  localparam logic [6:0] SLAVE_ADDR      = 7'h1e;
  localparam logic [4:0] MCODE_PREFIX    = 5'h01;
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam logic [2:0] LAST_BIT        = 3'h7;
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_VOUT        = 8'h01;
  localparam logic [7:0] UNMAPPED_DATA   = 8'h00;
  localparam int         CTRL_SPREAD     = 7;
  localparam int         CTRL_RAMP       = 6;
  localparam int         CTRL_CURRENT_LIMIT_PIN_HI    = 5;
  localparam int         CTRL_CURRENT_LIMIT_PIN_LO    = 4;
  localparam int         CTRL_FACTORY    = 3;
  localparam int         CTRL_RSVD       = 2;
  localparam int         CTRL_AND_MODE   = 1;
  localparam int         CTRL_SW_EN      = 0;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] VOUT_RESET_LOW  = 8'h06;
  localparam logic [7:0] VOUT_RESET_MID  = 8'h24;
  localparam logic [7:0] VOUT_RESET_HIGH = 8'h46;
  localparam logic [7:0] VOUT_CODE_MAX   = 8'h78;
  localparam int         SYNC_LINES      = 4;
  localparam int         LINE_SCL        = 0;
  localparam int         LINE_SDA        = 1;
  localparam int         LINE_EN         = 2;
  localparam int         LINE_LIM        = 3;
endpackage

// File: rics_line_if.sv
// Synchronised bus events and pin levels passed to the protocol engine.
`timescale 1ns/1ps
interface rics_line_if;
  logic sclRise;
  logic sclFall;
  logic sdaLevel;
  logic startSeen;
  logic stopSeen;
  logic enPinLevel;
  logic limPinLevel;
  modport producer (output sclRise, sclFall, sdaLevel, startSeen, stopSeen,
                    enPinLevel, limPinLevel);
  modport consumer (input sclRise, sclFall, sdaLevel, startSeen, stopSeen,
                    enPinLevel, limPinLevel);
endinterface

// File: rics_pin_sync.sv
// Two-flop synchronisers and bus condition detection for the serial pins.
`timescale 1ns/1ps
module rics_pin_sync
  import rics_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  input  wire logic       enPin,
  input  wire logic       limPin,
  rics_line_if.producer   lines
);
  logic [SYNC_LINES-1:0] rawIn;
  logic [SYNC_LINES-1:0] meta_ff;
  logic [SYNC_LINES-1:0] sync_ff;
  logic [SYNC_LINES-1:0] nxt_meta;
  logic [SYNC_LINES-1:0] nxt_sync;
  logic                  sclPrev_ff;
  logic                  sdaPrev_ff;

  assign rawIn = {limPin, enPin, sdaIn, sclIn};

  // Every pin gets the same pair of stages.
  genvar g;
  generate
    for (g = 0; g < SYNC_LINES; g++) begin : gSync
      always_comb begin
        nxt_meta[g] = rawIn[g];
        nxt_sync[g] = meta_ff[g];
      end
      always_ff @(posedge sys_clk or posedge rst) begin
        // Bus lines rest high; the enable and limit lanes rest low so the
        // regulator cannot pulse on while the pins are still being sampled.
        if (rst) begin
          meta_ff[g] <= (g == LINE_SCL) || (g == LINE_SDA);
          sync_ff[g] <= (g == LINE_SCL) || (g == LINE_SDA);
        end else begin
          meta_ff[g] <= nxt_meta[g];
          sync_ff[g] <= nxt_sync[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else begin
      sclPrev_ff <= sync_ff[LINE_SCL];
      sdaPrev_ff <= sync_ff[LINE_SDA];
    end
  end

  // Data edges only count as conditions while the clock stays high.
  assign lines.sclRise     = sync_ff[LINE_SCL] & ~sclPrev_ff;
  assign lines.sclFall     = ~sync_ff[LINE_SCL] & sclPrev_ff;
  assign lines.sdaLevel    = sync_ff[LINE_SDA];
  assign lines.startSeen   = sclPrev_ff & sync_ff[LINE_SCL] & sdaPrev_ff
                             & ~sync_ff[LINE_SDA];
  assign lines.stopSeen    = sclPrev_ff & sync_ff[LINE_SCL] & ~sdaPrev_ff
                             & sync_ff[LINE_SDA];
  assign lines.enPinLevel  = sync_ff[LINE_EN];
  assign lines.limPinLevel = sync_ff[LINE_LIM];
endmodule // rics_pin_sync

// File: rics_cfg_slave.sv
// Serial configuration slave with the two regulator control registers.
`timescale 1ns/1ps
module rics_cfg_slave
  import rics_pkg::*;
#(
  parameter logic [1:0] VARIANT      = 2'h0,
  parameter logic       FACTORY_BIT  = 1'b0,
  parameter logic       EXT_FEEDBACK = 1'b0
)(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       enPin,
  input  wire logic       currentLimitPin,
  output logic            spreadModulationOn,
  output logic            rampTimeSelect,
  output logic [1:0]      peakLimitCode,
  output logic            peakLimitApplied,
  output logic            regulatorOn,
  output logic [7:0]      outputVoltageCode,
  output logic            voltageCodeApplied,
  output logic            fastFilterSel
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_HS_NACK
  } rics_state_t;

  localparam logic [7:0] VOUT_RESET = (VARIANT == 2'h2) ? VOUT_RESET_HIGH :
                                      (VARIANT == 2'h1) ? VOUT_RESET_MID :
                                                          VOUT_RESET_LOW;

  // factory strap at reset
  // The factory bit reads as its strap value even before any write.
  localparam logic [7:0] CTRL_START = CTRL_RESET
                                      | (8'(FACTORY_BIT) << CTRL_FACTORY);

  rics_line_if lines ();

  rics_pin_sync u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sclIn   (sclIn),
    .sdaIn   (sdaIn),
    .enPin   (enPin),
    .limPin  (currentLimitPin),
    .lines   (lines.producer)
  );

  rics_state_t state_ff;
  rics_state_t nxt_state;
  logic [3:0]  bitCnt_ff;
  logic [3:0]  nxt_bitCnt;
  logic [7:0]  shift_ff;
  logic [7:0]  nxt_shift;
  logic [7:0]  ptr_ff;
  logic [7:0]  nxt_ptr;
  logic [7:0]  ctrl_ff;
  logic [7:0]  nxt_ctrl;
  logic [7:0]  vout_ff;
  logic [7:0]  nxt_vout;
  logic        readMode_ff;
  logic        nxt_readMode;
  logic        sdaOe_ff;
  logic        nxt_sdaOe;
  logic        hs_ff;
  logic        nxt_hs;
  logic [7:0]  readData;

  logic        spread_ff;
  logic        ramp_ff;
  logic [1:0]  current_limit_pin_ff;
  logic        ilimApplied_ff;
  logic        regOn_ff;
  logic [7:0]  voutOut_ff;
  logic        voutApplied_ff;
  logic        nxt_spread;
  logic        nxt_ramp;
  logic [1:0]  nxt_current_limit_pin;
  logic        nxt_ilimApplied;
  logic        nxt_regOn;
  logic [7:0]  nxt_voutOut;
  logic        nxt_voutApplied;

  always_comb begin
    case (ptr_ff)
      REG_CTRL: readData = ctrl_ff;
      REG_VOUT: readData = vout_ff;
      default:  readData = UNMAPPED_DATA;
    endcase
  end

  always_comb begin
    nxt_state    = state_ff;
    nxt_bitCnt   = bitCnt_ff;
    nxt_shift    = shift_ff;
    nxt_ptr      = ptr_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_vout     = vout_ff;
    nxt_readMode = readMode_ff;
    nxt_sdaOe    = sdaOe_ff;
    nxt_hs       = hs_ff;
    if (lines.stopSeen) begin
      nxt_state = ST_IDLE;
      nxt_sdaOe = 1'b0;
      nxt_hs    = 1'b0;
    end else if (lines.startSeen) begin
      nxt_state  = ST_ADDR;
      nxt_bitCnt = 4'h0;
      nxt_sdaOe  = 1'b0;
    end else begin
      case (state_ff)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (lines.sclRise && bitCnt_ff != BYTE_BITS) begin
            nxt_shift  = {shift_ff[6:0], lines.sdaLevel};
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end else if (lines.sclFall && bitCnt_ff == BYTE_BITS) begin
            nxt_bitCnt = 4'h0;
            nxt_sdaOe  = 1'b1;
            if (state_ff == ST_ADDR) begin
              if (shift_ff[7:3] == MCODE_PREFIX) begin
                nxt_state = ST_HS_NACK;
                nxt_sdaOe = 1'b0;
                nxt_hs    = 1'b1;
              end else if (shift_ff[7:1] == SLAVE_ADDR) begin
                nxt_state    = ST_ADDR_ACK;
                nxt_readMode = shift_ff[0];
              end else begin
                nxt_state = ST_IDLE;
                nxt_sdaOe = 1'b0;
              end
            end else if (state_ff == ST_PTR) begin
              nxt_state = ST_PTR_ACK;
              nxt_ptr   = shift_ff;
            end else begin
              if (ptr_ff == REG_CTRL) begin
                nxt_ctrl = shift_ff;
                nxt_ctrl[CTRL_FACTORY] = FACTORY_BIT;
              end else if (ptr_ff == REG_VOUT) begin
                nxt_vout = shift_ff;
              end
              nxt_ptr   = ptr_ff + 8'h01;
              nxt_state = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (lines.sclFall) begin
            if (readMode_ff) begin
              nxt_state  = ST_RDATA;
              nxt_shift  = readData;
              nxt_sdaOe  = ~readData[7];
              nxt_bitCnt = 4'h0;
            end else begin
              nxt_state  = ST_PTR;
              nxt_sdaOe  = 1'b0;
              nxt_bitCnt = 4'h0;
            end
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          if (lines.sclFall) begin
            nxt_state  = ST_WDATA;
            nxt_sdaOe  = 1'b0;
            nxt_bitCnt = 4'h0;
          end
        end
        ST_RDATA: begin
          if (lines.sclFall) begin
            if (bitCnt_ff[2:0] == LAST_BIT) begin
              nxt_state = ST_RACK;
              nxt_sdaOe = 1'b0;
              nxt_ptr   = ptr_ff + 8'h01;
            end else begin
              nxt_shift  = {shift_ff[6:0], 1'b0};
              nxt_sdaOe  = ~shift_ff[6];
              nxt_bitCnt = bitCnt_ff + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (lines.sclRise && lines.sdaLevel) begin
            nxt_state = ST_IDLE;
          end else if (lines.sclFall) begin
            nxt_state  = ST_RDATA;
            nxt_shift  = readData;
            nxt_sdaOe  = ~readData[7];
            nxt_bitCnt = 4'h0;
          end
        end
        ST_HS_NACK: begin
          if (lines.sclFall) begin
            nxt_state = ST_IDLE;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff    <= ST_IDLE;
      bitCnt_ff   <= 4'h0;
      shift_ff    <= 8'h00;
      ptr_ff      <= 8'h00;
      ctrl_ff     <= CTRL_START;
      vout_ff     <= VOUT_RESET;
      readMode_ff <= 1'b0;
      sdaOe_ff    <= 1'b0;
      hs_ff       <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      bitCnt_ff   <= nxt_bitCnt;
      shift_ff    <= nxt_shift;
      ptr_ff      <= nxt_ptr;
      ctrl_ff     <= nxt_ctrl;
      vout_ff     <= nxt_vout;
      readMode_ff <= nxt_readMode;
      sdaOe_ff    <= nxt_sdaOe;
      hs_ff       <= nxt_hs;
    end
  end

  always_comb begin
    nxt_spread      = ctrl_ff[CTRL_SPREAD];
    nxt_ramp        = ctrl_ff[CTRL_RAMP];
    // peak limit only while pin low
    nxt_current_limit_pin        = ctrl_ff[CTRL_CURRENT_LIMIT_PIN_HI:CTRL_CURRENT_LIMIT_PIN_LO];
    nxt_ilimApplied = ~lines.limPinLevel;
    nxt_regOn       = ctrl_ff[CTRL_AND_MODE] ?
                      (ctrl_ff[CTRL_SW_EN] & lines.enPinLevel) :
                      (ctrl_ff[CTRL_SW_EN] | lines.enPinLevel);
    nxt_voutOut     = vout_ff;
    nxt_voutApplied = ~EXT_FEEDBACK;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      spread_ff      <= 1'b0;
      ramp_ff        <= 1'b0;
      current_limit_pin_ff        <= 2'h0;
      ilimApplied_ff <= 1'b0;
      regOn_ff       <= 1'b0;
      voutOut_ff     <= VOUT_RESET;
      voutApplied_ff <= 1'b0;
    end else begin
      spread_ff      <= nxt_spread;
      ramp_ff        <= nxt_ramp;
      current_limit_pin_ff        <= nxt_current_limit_pin;
      ilimApplied_ff <= nxt_ilimApplied;
      regOn_ff       <= nxt_regOn;
      voutOut_ff     <= nxt_voutOut;
      voutApplied_ff <= nxt_voutApplied;
    end
  end

  assign sdaOut             = 1'b0;
  assign sdaOe              = sdaOe_ff;
  assign sclOut             = 1'b0;
  assign sclOe              = 1'b0;
  assign spreadModulationOn = spread_ff;
  assign rampTimeSelect     = ramp_ff;
  assign peakLimitCode      = current_limit_pin_ff;
  assign peakLimitApplied   = ilimApplied_ff;
  assign regulatorOn        = regOn_ff;
  assign outputVoltageCode  = voutOut_ff;
  assign voltageCodeApplied = voutApplied_ff;
  assign fastFilterSel      = hs_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_byteEnd(rics_state_t st);
    state_ff == st && lines.sclFall && bitCnt_ff == BYTE_BITS
      && !lines.startSeen && !lines.stopSeen;
  endsequence

  a_addr_ack: assert property (
    s_byteEnd(ST_ADDR) ##0 shift_ff[7:1] == SLAVE_ADDR
      |=> sdaOe_ff && state_ff == ST_ADDR_ACK)
    else $error("address byte not acknowledged");
  a_read_first: assert property (
    state_ff == ST_ADDR_ACK && readMode_ff && lines.sclFall
      && !lines.startSeen && !lines.stopSeen
      |=> sdaOe_ff == ~$past(readData[7]) && state_ff == ST_RDATA)
    else $error("first read bit wrong");
  a_rack_end: assert property (
    state_ff == ST_RACK && lines.sclRise && lines.sdaLevel
      && !lines.startSeen && !lines.stopSeen |=> state_ff == ST_IDLE)
    else $error("read continued after not-acknowledge");
  a_stop_filter: assert property (
    lines.stopSeen |=> !hs_ff)
    else $error("stop did not restore slow filters");
  a_stop_ptr: assert property (
    lines.stopSeen |=> ptr_ff == $past(ptr_ff))
    else $error("stop changed the pointer");
  a_mcode_nack: assert property (
    s_byteEnd(ST_ADDR) ##0 shift_ff[7:3] == MCODE_PREFIX
      |=> !sdaOe_ff && hs_ff && state_ff == ST_HS_NACK)
    else $error("master code not handled");
  a_hs_keep: assert property (
    lines.startSeen && !lines.stopSeen && hs_ff |=> hs_ff)
    else $error("repeated start dropped fast mode");
  a_ptr_ack: assert property (
    s_byteEnd(ST_PTR) |=> sdaOe_ff && ptr_ff == $past(shift_ff))
    else $error("pointer byte not acknowledged");
  a_factory_bit: assert property (
    s_byteEnd(ST_WDATA) ##0 ptr_ff == REG_CTRL
      |=> ctrl_ff[CTRL_FACTORY] == FACTORY_BIT)
    else $error("factory bit was written");
  a_write_now: assert property (
    s_byteEnd(ST_WDATA) ##0 ptr_ff == REG_VOUT
      |=> vout_ff == $past(shift_ff) ##1 outputVoltageCode == $past(vout_ff))
    else $error("write did not take effect");
  a_ptr_incr: assert property (
    state_ff == ST_RDATA && lines.sclFall && bitCnt_ff[2:0] == LAST_BIT
      && !lines.startSeen && !lines.stopSeen
      |=> ptr_ff == $past(ptr_ff) + 8'h01)
    else $error("pointer did not advance");
  a_enable_or: assert property (
    !ctrl_ff[CTRL_AND_MODE] && !ctrl_ff[CTRL_SW_EN] && !lines.enPinLevel
      |=> !regulatorOn)
    else $error("regulator enabled with both enables low");
endmodule // rics_cfg_slave

// File: rics_bfm.sv
// Behavioural two-wire bus master that drives the slave's serial pins.
`timescale 1ns/1ps
module rics_bfm (
  input  wire logic sys_clk,
  input  wire logic sdaWire,
  output logic      sclLow,
  output logic      sdaLow
);
  // The master only pulls lines low; the pull-ups supply the high level.
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  task automatic waitClk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic busStart();
    waitClk(4);
    sdaLow = 1'b0;
    waitClk(4);
    sclLow = 1'b0;
    waitClk(8);
    sdaLow = 1'b1;
    waitClk(8);
    sclLow = 1'b1;
  endtask

  task automatic busStop();
    waitClk(4);
    sdaLow = 1'b1;
    waitClk(4);
    sclLow = 1'b0;
    waitClk(8);
    sdaLow = 1'b0;
    waitClk(8);
  endtask

  // Data is set late in the low phase, after the slave's answer has moved.
  task automatic bitCycle(input logic drvLow, output logic seen);
    waitClk(6);
    sdaLow = drvLow;
    waitClk(2);
    sclLow = 1'b0;
    waitClk(4);
    seen = sdaWire;
    waitClk(4);
    sclLow = 1'b1;
  endtask

  // bytes sent most significant bit first
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(~b[i], seen);
    end
    bitCycle(1'b0, seen);
    ack = ~seen;
  endtask

  // acknowledge for more, not-acknowledge after the last
  task automatic recvByte(input logic more, output logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b0, seen);
      b[i] = seen;
    end
    bitCycle(more, seen);
  endtask
endmodule // rics_bfm

// File: test_rics_cfg_slave.sv
// Self-checking bench for the regulator configuration serial slave.
`timescale 1ns/1ps
module test_rics_cfg_slave;
  import rics_pkg::*;
  localparam logic FACT = 1'b1;
  logic       sys_clk         = 1'b0;
  logic       rst             = 1'b1;
  logic       enPin           = 1'b0;
  logic       currentLimitPin = 1'b0;
  logic       sclLow, sdaLow, sdaOut, sdaOe, sclOut, sclOe;
  logic       spreadModulationOn, rampTimeSelect, peakLimitApplied;
  logic       regulatorOn, voltageCodeApplied, fastFilterSel;
  logic [1:0] peakLimitCode;
  logic [7:0] outputVoltageCode;
  logic       sclHeld         = 1'b0;
  logic       ack;
  logic [7:0] ctrl, vout, rd, uptr;
  int         fail_count      = 0;
  int         n_compared      = 0;
  int         seed            = 32'ha9fa;
  wire        sclWire = ~(sclLow | (sclOe & ~sclOut));
  wire        sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));

  always #5 sys_clk = ~sys_clk;

  rics_cfg_slave #(.VARIANT(2'h1), .FACTORY_BIT(FACT), .EXT_FEEDBACK(1'b0))
    rics_cfg_slave_i (
    .sys_clk(sys_clk), .rst(rst), .sclIn(sclWire), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOut(sclOut), .sclOe(sclOe),
    .enPin(enPin), .currentLimitPin(currentLimitPin),
    .spreadModulationOn(spreadModulationOn), .rampTimeSelect(rampTimeSelect),
    .peakLimitCode(peakLimitCode), .peakLimitApplied(peakLimitApplied),
    .regulatorOn(regulatorOn), .outputVoltageCode(outputVoltageCode),
    .voltageCodeApplied(voltageCodeApplied), .fastFilterSel(fastFilterSel));

  rics_bfm rics_bfm_i (.sys_clk(sys_clk), .sdaWire(sdaWire),
                       .sclLow(sclLow), .sdaLow(sdaLow));

  always @(posedge sys_clk) begin
    if (!rst && sclOe !== 1'b0) sclHeld <= 1'b1;
  end

  task automatic checkBit(input string what, input logic e, input logic s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, s);
    end
  endtask

  task automatic checkByte(input string what, input logic [7:0] e,
                           input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic complete_run();
    $display("Compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic put(input logic [7:0] b, input logic expAck);
    rics_bfm_i.sendByte(b, ack);
    checkBit("ack", expAck, ack);
  endtask

  // Outputs land a few cycles after the serial clock edge that caused them.
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask

  function automatic logic [7:0] expCtrl(input logic [7:0] w);
    expCtrl = w;
    expCtrl[CTRL_FACTORY] = FACT;
  endfunction

  function automatic logic expOn(input logic [7:0] c, input logic en);
    expOn = c[CTRL_AND_MODE] ? (c[CTRL_SW_EN] & en) : (c[CTRL_SW_EN] | en);
  endfunction

  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    checkByte("vout reset", VOUT_RESET_MID, outputVoltageCode);
    checkBit("spread reset", 1'b0, spreadModulationOn);
    checkBit("ramp reset", 1'b0, rampTimeSelect);
    checkBit("code applied", 1'b1, voltageCodeApplied);
    checkBit("slow filters", 1'b0, fastFilterSel);
    rics_bfm_i.busStart();
    put({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b0);
    rics_bfm_i.busStop();
    rics_bfm_i.busStart();
    put({SLAVE_ADDR, 1'b0}, 1'b1);
    put(REG_CTRL, 1'b1);
    rics_bfm_i.busStart();
    put({SLAVE_ADDR, 1'b1}, 1'b1);
    rics_bfm_i.recvByte(1'b0, rd);
    checkByte("ctrl reset", expCtrl(CTRL_RESET), rd);
    rics_bfm_i.busStop();
    for (int i = 0; i < 8; i++) begin
      ctrl = 8'($random(seed));
      ctrl[CTRL_RSVD] = 1'b0;
      ctrl[CTRL_SW_EN] = i[0];
      ctrl[CTRL_AND_MODE] = i[1];
      // voltage code kept in range, both ends included
      vout = 8'($random(seed) & 32'h7f);
      if (vout > VOUT_CODE_MAX || i == 7) vout = VOUT_CODE_MAX;
      if (i == 0) vout = 8'h00;
      enPin = i[2];
      currentLimitPin = 1'($random(seed));
      rics_bfm_i.busStart();
      put({SLAVE_ADDR, 1'b0}, 1'b1);
      put(REG_CTRL, 1'b1);
      put(ctrl, 1'b1);
      settle();
      checkBit("spread", ctrl[CTRL_SPREAD], spreadModulationOn);
      checkBit("ramp", ctrl[CTRL_RAMP], rampTimeSelect);
      checkByte("limit", {6'h00, ctrl[CTRL_CURRENT_LIMIT_PIN_HI:CTRL_CURRENT_LIMIT_PIN_LO]},
                {6'h00, peakLimitCode});
      checkBit("limit used", ~currentLimitPin, peakLimitApplied);
      checkBit("run", expOn(ctrl, enPin), regulatorOn);
      put(vout, 1'b1);
      settle();
      checkByte("vout", vout, outputVoltageCode);
      rics_bfm_i.busStop();
      rics_bfm_i.busStart();
      put({SLAVE_ADDR, 1'b0}, 1'b1);
      put(REG_CTRL, 1'b1);
      rics_bfm_i.busStart();
      put({SLAVE_ADDR, 1'b1}, 1'b1);
      rics_bfm_i.recvByte(1'b1, rd);
      checkByte("read ctrl", expCtrl(ctrl), rd);
      rics_bfm_i.recvByte(1'b1, rd);
      checkByte("read vout", vout, rd);
      rics_bfm_i.recvByte(1'b0, rd);
      checkByte("read unmapped", UNMAPPED_DATA, rd);
      rics_bfm_i.busStop();
    end
    rics_bfm_i.busStart();
    put({SLAVE_ADDR, 1'b0}, 1'b1);
    put(REG_VOUT, 1'b1);
    rics_bfm_i.busStop();
    rics_bfm_i.busStart();
    put({SLAVE_ADDR, 1'b1}, 1'b1);
    rics_bfm_i.recvByte(1'b0, rd);
    checkByte("ptr after stop", vout, rd);
    rics_bfm_i.busStop();
    rics_bfm_i.busStart();
    put({SLAVE_ADDR, 1'b1}, 1'b1);
    rics_bfm_i.recvByte(1'b0, rd);
    checkByte("ptr advanced", UNMAPPED_DATA, rd);
    rics_bfm_i.busStop();
    uptr = 8'h80 | 8'($random(seed));
    rics_bfm_i.busStart();
    put({MCODE_PREFIX, 3'($random(seed))}, 1'b0);
    settle();
    checkBit("fast filters", 1'b1, fastFilterSel);
    rics_bfm_i.busStart();
    put({SLAVE_ADDR, 1'b0}, 1'b1);
    put(uptr, 1'b1);
    put(8'h5a, 1'b1);
    checkBit("fast kept", 1'b1, fastFilterSel);
    rics_bfm_i.busStart();
    checkBit("fast after sr", 1'b1, fastFilterSel);
    put({SLAVE_ADDR, 1'b0}, 1'b1);
    put(uptr, 1'b1);
    rics_bfm_i.busStart();
    put({SLAVE_ADDR, 1'b1}, 1'b1);
    rics_bfm_i.recvByte(1'b0, rd);
    checkByte("unmapped write", UNMAPPED_DATA, rd);
    checkByte("vout kept", VOUT_CODE_MAX, outputVoltageCode);
    rics_bfm_i.busStop();
    settle();
    checkBit("slow after stop", 1'b0, fastFilterSel);
    checkBit("clock hold", 1'b0, sclHeld);
    complete_run();
  end
endmodule // test_rics_cfg_slave
